// ===== core/arp_port.sv
// converter result output port: parallel, master and slave serial
`timescale 1ns/1ps
module arp_port (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic conversion_trigger_low,
  input wire logic [15:0] conv_result,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic byte_order_select,
  input wire logic serial_parallel_select,
  input wire logic clock_source_select,
  input wire logic clock_polarity_invert,
  input wire logic frame_polarity_invert,
  input wire logic read_timing_select,
  input wire logic [1:0] clock_divider_select,
  input wire logic serial_result_clock_in,
  input wire logic chain_serial_input,
  input wire logic host_ready,
  output logic [15:0] data_out,
  output logic [15:0] data_oe,
  output logic serial_result_out,
  output logic serial_result_out_oe,
  output logic serial_result_clock_out,
  output logic serial_result_clock_oe,
  output logic frame_out,
  output logic busy,
  output logic read_overrun_flag,
  output logic config_port_enable,
  output logic word_valid,
  output logic [15:0] word_data
);
  // ****************************************************************
  // conversion sequencer
  // ****************************************************************
  typedef enum logic [1:0] {ARP_IDLE, ARP_CONV, ARP_SEND} arp_state_t;
  arp_state_t state_q;
  logic trig_q;
  logic [arp_pkg::CONV_W-1:0] conv_cnt_q;
  logic [15:0] result_q;
  logic conv_done;
  logic start;
  logic master;
  logic slave;
  logic rdc_mode;
  logic shift_en;
  logic [15:0] shreg_q;
  logic [arp_pkg::CNT_W-1:0] bit_cnt_q;
  logic [arp_pkg::DIV_W-1:0] div_cnt_q;
  logic mclk_q;
  logic sclk_q;
  logic fall_edge;
  logic rise_edge;
  logic mst_active_q;
  logic sel;
  logic [arp_pkg::DIV_W-1:0] half_per;
  logic buf_in_ready;

  assign master = serial_parallel_select && !clock_source_select;
  assign slave = serial_parallel_select && clock_source_select;
  assign rdc_mode = read_timing_select;
  assign sel = !cs_n && !rd_n;
  assign start = trig_q && !conversion_trigger_low && state_q == ARP_IDLE;
  assign conv_done = state_q == ARP_CONV &&
    conv_cnt_q == arp_pkg::CONV_W'(arp_pkg::CONV_CYC - 1);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      trig_q <= 1'b1;
    end else begin
      trig_q <= conversion_trigger_low;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ARP_IDLE;
      conv_cnt_q <= '0;
    end else begin
      case (state_q)
        ARP_IDLE: begin
          conv_cnt_q <= '0;
          if (start) begin
            state_q <= ARP_CONV;
          end
        end
        ARP_CONV: begin
          conv_cnt_q <= conv_cnt_q + 1'b1;
          if (conv_done) begin
            state_q <= (master && !rdc_mode) ? ARP_SEND : ARP_IDLE;
          end
        end
        ARP_SEND: begin
          if (!mst_active_q) begin
            state_q <= ARP_IDLE;
          end
        end
        default: state_q <= ARP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      result_q <= arp_pkg::RESULT_RESET;
    end else if (conv_done) begin
      result_q <= conv_result;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= start || (state_q == ARP_CONV && !conv_done) ||
        (state_q == ARP_CONV && master && !rdc_mode) || (state_q == ARP_SEND && mst_active_q);
    end
  end

  // ****************************************************************
  // serial clock: generated divider or external edge detect
  // ****************************************************************
  always_comb begin
    half_per = arp_pkg::DIV_BASE << clock_divider_select;
    if (rdc_mode) begin
      half_per = (bit_cnt_q <= arp_pkg::CNT_W'(arp_pkg::LSB_SLOW_BITS)) ?
        arp_pkg::RDC_SLOW : arp_pkg::RDC_FAST;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= serial_result_clock_in ^ clock_polarity_invert;
    end
  end

  logic ext_rise;
  logic ext_fall;
  assign ext_rise = slave && sel && !sclk_q && (serial_result_clock_in ^ clock_polarity_invert);
  assign ext_fall = slave && sel && sclk_q && !(serial_result_clock_in ^ clock_polarity_invert);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mst_active_q <= 1'b0;
      div_cnt_q <= '0;
      mclk_q <= 1'b0;
    end else if (!mst_active_q) begin
      mclk_q <= 1'b0;
      div_cnt_q <= '0;
      mst_active_q <= master && (rdc_mode ? start : conv_done) && buf_in_ready;
    end else if (div_cnt_q == half_per - 1'b1) begin
      div_cnt_q <= '0;
      mclk_q <= !mclk_q;
      if (mclk_q && bit_cnt_q == arp_pkg::CNT_W'(1)) begin
        mst_active_q <= 1'b0;
      end
    end else begin
      div_cnt_q <= div_cnt_q + 1'b1;
    end
  end

  assign rise_edge = (mst_active_q && !mclk_q && div_cnt_q == half_per - 1'b1) || ext_rise;
  assign fall_edge = (mst_active_q && mclk_q && div_cnt_q == half_per - 1'b1) || ext_fall;
  assign shift_en = fall_edge;

  // ****************************************************************
  // shift register with chain input
  // ****************************************************************
  logic chain_q;
  logic load;
  assign load = (master && !mst_active_q && (rdc_mode ? start : conv_done)) ||
    (slave && conv_done);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shreg_q <= arp_pkg::RESULT_RESET;
      bit_cnt_q <= '0;
      chain_q <= 1'b0;
    end else if (load) begin
      shreg_q <= (master && rdc_mode) ? result_q : conv_result;
      bit_cnt_q <= arp_pkg::BITS_C;
    end else begin
      if (rise_edge) begin
        chain_q <= chain_serial_input;
      end
      if (shift_en && bit_cnt_q != '0) begin
        shreg_q <= {shreg_q[14:0], chain_q};
        bit_cnt_q <= bit_cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      read_overrun_flag <= 1'b0;
    end else begin
      read_overrun_flag <= slave && rdc_mode && conv_done &&
        bit_cnt_q != '0 && bit_cnt_q != arp_pkg::BITS_C;
    end
  end

  // ****************************************************************
  // two-entry result buffer toward the word stream
  // ****************************************************************
  logic [15:0] buf_q [2];
  logic [1:0] buf_cnt_q;
  logic buf_rd_q;
  logic buf_push;
  logic buf_pop;
  logic buf_wr_idx;
  logic buf_nxt_rd;
  assign buf_in_ready = buf_cnt_q != 2'h2;
  assign buf_wr_idx = buf_rd_q ^ buf_cnt_q[0];
  assign buf_nxt_rd = buf_pop ? !buf_rd_q : buf_rd_q;
  assign buf_push = conv_done && buf_in_ready;
  assign buf_pop = word_valid && host_ready;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      buf_cnt_q <= '0;
      buf_rd_q <= 1'b0;
      word_valid <= 1'b0;
      word_data <= arp_pkg::RESULT_RESET;
    end else begin
      if (buf_push) begin
        buf_q[buf_wr_idx] <= conv_result;
      end
      if (buf_pop) begin
        buf_rd_q <= !buf_rd_q;
      end
      buf_cnt_q <= buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
      word_valid <= (buf_cnt_q - {1'b0, buf_pop} + {1'b0, buf_push}) != '0;
      // bypass so a word written into the new head shows at once
      word_data <= (buf_push && buf_wr_idx == buf_nxt_rd) ? conv_result : buf_q[buf_nxt_rd];
    end
  end

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_out <= '0;
      data_oe <= '0;
      serial_result_out <= 1'b0;
      serial_result_out_oe <= 1'b0;
      serial_result_clock_out <= 1'b0;
      serial_result_clock_oe <= 1'b0;
      frame_out <= 1'b0;
      config_port_enable <= 1'b0;
    end else begin
      config_port_enable <= serial_parallel_select;
      data_out <= byte_order_select ? {result_q[7:0], result_q[15:8]} : result_q;
      data_oe <= (sel && !serial_parallel_select) ? 16'hFFFF : 16'h0000;
      serial_result_out <= shreg_q[15];
      serial_result_out_oe <= sel && serial_parallel_select;
      serial_result_clock_out <= mclk_q ^ clock_polarity_invert;
      serial_result_clock_oe <= sel && master;
      frame_out <= mst_active_q ^ frame_polarity_invert;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  lane_normal_a: assert property (@(posedge clk_sys) disable iff (rst)
    !byte_order_select |=> data_out == $past(result_q)) else $error("lane order wrong");
  lane_swap_a: assert property (@(posedge clk_sys) disable iff (rst)
    byte_order_select |=> data_out[15:8] == $past(result_q[7:0]))
    else $error("swap wrong");
  bus_release_a: assert property (@(posedge clk_sys) disable iff (rst)
    (cs_n || rd_n) |=> data_oe == 16'h0000 && !serial_result_out_oe)
    else $error("bus not released");
  busy_send_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == ARP_SEND && mst_active_q |=> busy) else $error("busy dropped early");
  result_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !conv_done |=> $stable(result_q)) else $error("result changed");
  overrun_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
    read_overrun_flag |=> !read_overrun_flag) else $error("overrun not a pulse");
  no_restart_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == ARP_CONV && !conv_done |=> state_q == ARP_CONV) else $error("restarted");
  cfg_serial_a: assert property (@(posedge clk_sys) disable iff (rst)
    !serial_parallel_select |=> !config_port_enable) else $error("config port on");
endmodule

// ===== inc/arp_pkg.sv
// constants for the converter result output port
// ****************************************************************
// Behaviour
// - byte order low puts low byte on d[7:0], high byte on d[15:8].
// - byte order high swaps lanes: low byte on d[15:8], high on d[7:0].
// - lane swap works in continuous and strobed parallel reading.
// - serial select high runs serial port on shared data pins.
// - serial result shifts out sixteen bits, msb first, one per pulse.
// - configuration port pins usable only while serial mode is on.
// - internal clock source makes serial clock and a frame signal.
// - polarity inputs invert generated clock and frame signal.
// - read-after-convert master keeps busy high until sixteen bits sent; code sends none and drops busy while the result buffer is full.
// - two-bit divider sets generated clock period, clock runs in transfer only.
// - read-during-convert master sends previous result, two clock periods; code sends none if the result buffer is full at start.
// - external clock shifts only while select and read both low.
// - external clock may idle high or low.
// - slave read after busy falls, sixteen pulses, msb first.
// - chain input captured on edge opposite the shifting edge.
// - unfinished read at conversion end pulses overrun flag; code pulses it only in slave read-during-convert.
// - slave read may span into the next conversion.
// - select or read high releases all interface outputs; code keeps the frame output driven.
// - reset aborts conversion, releases bus, clears state.
// - trigger falling edge starts conversion that cannot be restarted.
// ****************************************************************
package arp_pkg;
  localparam int CLK_MHZ = 250;
  localparam int CONV_NS = 1450;
  localparam int CONV_CYC = (CONV_NS * CLK_MHZ) / 1000;
  localparam int HALF_CONV_CYC = CONV_CYC / 2;
  localparam int BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] BITS_C = 5'h10;
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] DIV_BASE = 4'h1;
  localparam logic [DIV_W-1:0] RDC_FAST = 4'h2;
  localparam logic [DIV_W-1:0] RDC_SLOW = 4'h5;
  localparam int LSB_SLOW_BITS = 4;
  localparam int CONV_W = 12;
  localparam int SHIFT_EDGE = 1;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
endpackage

// ===== testbench/arp_host_model.sv
// host model: collects master serial words and paces the result stream
`timescale 1ns/1ps
module arp_host_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic frame,
  input wire logic clk_inv,
  input wire logic frame_inv,
  output logic host_ready,
  output logic [15:0] rx_word,
  output logic [4:0] rx_cnt
);
  logic sclk_q;
  logic frame_q;
  logic fa;
  assign fa = frame ^ frame_inv;
  // capture on the internal rising edge, data shifted on the falling one
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sclk_q <= 1'b0;
      frame_q <= 1'b0;
      rx_cnt <= 5'h00;
      rx_word <= 16'h0000;
    end else begin
      sclk_q <= sclk ^ clk_inv;
      frame_q <= fa;
      if (fa && !frame_q) begin
        rx_cnt <= 5'h00;
      end else if (fa && (sclk ^ clk_inv) && !sclk_q) begin
        rx_word <= {rx_word[14:0], sdata};
        rx_cnt <= rx_cnt + 5'h01;
      end
    end
  end
  // random stalls on the result stream
  always_ff @(posedge clk_sys) begin
    host_ready <= rst ? 1'b0 : (($urandom % 4) != 0);
  end
endmodule

// ===== testbench/test_adc_result_output_port.sv
// self-checking bench for the converter result output port
`timescale 1ns/1ps
module test_adc_result_output_port;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic conversion_trigger_low = 1'b1;
  logic [15:0] conv_result = 16'h0000;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic byte_order_select = 1'b0;
  logic serial_parallel_select = 1'b0;
  logic clock_source_select = 1'b0;
  logic clock_polarity_invert = 1'b0;
  logic frame_polarity_invert = 1'b0;
  logic [1:0] clock_divider_select = 2'h0;
  logic read_timing_select = 1'b0;
  logic sclk_in = 1'b0;
  logic chain_in = 1'b0;
  int ovr_cnt = 0;
  logic host_ready;
  logic [15:0] data_out, data_oe, word_data, rx_word;
  logic serial_result_out, serial_result_out_oe, serial_result_clock_out;
  logic serial_result_clock_oe, frame_out, busy, read_overrun_flag;
  logic config_port_enable, word_valid;
  logic [4:0] rx_cnt;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [15:0] exp_q[$];
  always #2 clk_sys = ~clk_sys;
  arp_port arp_port_i (.clk_sys(clk_sys), .rst(rst),
    .conversion_trigger_low(conversion_trigger_low), .conv_result(conv_result),
    .cs_n(cs_n), .rd_n(rd_n), .byte_order_select(byte_order_select),
    .serial_parallel_select(serial_parallel_select),
    .clock_source_select(clock_source_select),
    .clock_polarity_invert(clock_polarity_invert),
    .frame_polarity_invert(frame_polarity_invert),
    .read_timing_select(read_timing_select),
    .clock_divider_select(clock_divider_select), .serial_result_clock_in(sclk_in),
    .chain_serial_input(chain_in), .host_ready(host_ready),
    .data_out(data_out), .data_oe(data_oe), .serial_result_out(serial_result_out),
    .serial_result_out_oe(serial_result_out_oe),
    .serial_result_clock_out(serial_result_clock_out),
    .serial_result_clock_oe(serial_result_clock_oe), .frame_out(frame_out),
    .busy(busy), .read_overrun_flag(read_overrun_flag),
    .config_port_enable(config_port_enable), .word_valid(word_valid),
    .word_data(word_data));
  arp_host_model arp_host_model_i (.clk_sys(clk_sys), .rst(rst),
    .sclk(serial_result_clock_out), .sdata(serial_result_out), .frame(frame_out),
    .clk_inv(clock_polarity_invert), .frame_inv(frame_polarity_invert),
    .host_ready(host_ready), .rx_word(rx_word), .rx_cnt(rx_cnt));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] lanes(input logic [15:0] v, input logic s);
    return s ? {v[7:0], v[15:8]} : v;
  endfunction
  task automatic end_sim();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic start_conv(input logic [15:0] v);
    conv_result <= v;
    exp_q.push_back(v);
    conversion_trigger_low <= 1'b0;
    @(posedge clk_sys);
    conversion_trigger_low <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic slave_pulses(input int n, output logic [15:0] w);
    w = 16'h0000;
    for (int k = 0; k < n; k++) begin
      w = {w[14:0], serial_result_out};
      sclk_in <= ~clock_polarity_invert;
      repeat (4) @(posedge clk_sys);
      sclk_in <= clock_polarity_invert;
      repeat (4) @(posedge clk_sys);
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 4000) chk(16'h0bad, 16'h0000);
    repeat (2) @(posedge clk_sys);
  endtask
  // ****************************************************************
  // result stream scoreboard
  // ****************************************************************
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 20000) begin
      error_cnt++;
      end_sim();
    end
    if (!rst && read_overrun_flag === 1'b1) ovr_cnt++;
    if (!rst && word_valid === 1'b1 && host_ready === 1'b1) begin
      if (exp_q.size() == 0) chk(word_data, 16'hxxxx);
      else chk(word_data, exp_q.pop_front());
    end
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [15:0] v, prev, w;
    logic s;
    logic c;
    void'($urandom(46320));
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    @(posedge clk_sys);
    prev = 16'h0000;
    s = 1'b0;
    for (int i = 0; i < 8; i++) begin
      v = (i < 2) ? 16'h00ff : 16'(($urandom));
      start_conv(v);
      repeat (100) @(posedge clk_sys);
      chk(data_out, lanes(prev, s));
      s = i[0];
      byte_order_select <= s;
      wait_idle();
      chk(data_out, lanes(v, s));
      chk(data_oe, 16'hffff);
      prev = v;
    end
    rd_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(data_oe, 16'h0000);
    chk({15'h0000, serial_result_out_oe}, 16'h0000);
    rd_n <= 1'b0;
    serial_parallel_select <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 16'h8001 : 16'(($urandom));
      clock_divider_select <= 2'(i);
      clock_polarity_invert <= 1'($urandom);
      frame_polarity_invert <= 1'($urandom);
      read_timing_select <= (i >= 6);
      repeat (2) @(posedge clk_sys);
      start_conv(v);
      wait_idle();
      chk(rx_word, (i >= 6) ? prev : v);
      prev = v;
      chk({11'h000, rx_cnt}, 16'h0010);
      chk({15'h0000, config_port_enable}, 16'h0001);
      chk({15'h0000, serial_result_clock_oe}, 16'h0001);
    end
    clock_source_select <= 1'b1;
    read_timing_select <= 1'b0;
    for (int j = 0; j < 2; j++) begin
      c = 1'($urandom);
      v = 16'($urandom);
      clock_polarity_invert <= j[0];
      sclk_in <= j[0];
      chain_in <= c;
      repeat (2) @(posedge clk_sys);
      start_conv(v);
      wait_idle();
      slave_pulses(16, w);
      chk(w, v);
      chk({15'h0000, serial_result_out}, {15'h0000, c});
    end
    read_timing_select <= 1'b1;
    v = 16'($urandom);
    start_conv(v);
    wait_idle();
    prev = v;
    v = 16'($urandom);
    start_conv(v);
    slave_pulses(4, w);
    chk({12'h000, w[3:0]}, {12'h000, prev[15:12]});
    wait_idle();
    chk(16'(ovr_cnt), 16'h0001);
    prev = v;
    v = 16'($urandom);
    start_conv(v);
    slave_pulses(16, w);
    chk(w, prev);
    wait_idle();
    chk(16'(ovr_cnt), 16'h0001);
    repeat (20) @(posedge clk_sys);
    chk(16'(exp_q.size()), 16'h0000);
    end_sim();
  end
endmodule
